/* hdl/fws_pkg.sv */
// constants and types shared by the flash status poll controller
package fws_pkg;
  // clock and flash bus timing
  localparam int CLK_NS    = 100;
  localparam int T_ACC_NS  = 70;   // read access time
  localparam int T_WP_NS   = 50;   // write strobe width, plain default
  localparam int ACC_CYC   = ((T_ACC_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                             (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC    = ((T_WP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                             (T_WP_NS + CLK_NS - 1) / CLK_NS;
  // flash bus widths
  localparam int FA_W      = 21;
  localparam int FD_W      = 16;
  // status bit positions on the flash data bus
  localparam int DQ_SECT   = 2;    // sector_toggle_bit
  localparam int DQ_TIMER  = 3;
  localparam int DQ_LIMIT  = 5;
  localparam int DQ_TOGGLE = 6;
  // register offsets of the controller
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SKIP   = 3;
  localparam int CTRL_YIELD  = 4;
  localparam logic [2:0] OP_POLL  = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_ADD   = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_OK   = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_PAUS = 3;
  localparam int ST_SECT = 4;
  localparam int ST_ERAS = 5;
  localparam int ST_REJ  = 6;
  localparam int ST_RDY  = 7;
  localparam int ST_LIM  = 8;
  // reset values
  localparam logic [FA_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [FD_W-1:0] DATA_RST = 16'h0000;
  // one flash bus cycle request
  typedef struct packed {
    logic            write;
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] data;
  } fws_req_t;
endpackage

/* hdl/fws_bus_cycle.sv */
// one asynchronous flash read or write cycle, paced by the system clock
`timescale 1ns/1ps
`default_nettype none
module fws_bus_cycle
(
  input  wire logic                    i_clock,
  input  wire logic                    i_resetn,
  input  wire logic                    i_start,
  input  wire fws_pkg::fws_req_t       i_req,
  input  wire logic [fws_pkg::FD_W-1:0] i_dq_in,
  output logic                         o_ce_n,
  output logic                         o_oe_n,
  output logic                         o_we_n,
  output logic [fws_pkg::FA_W-1:0]     o_addr,
  output logic [fws_pkg::FD_W-1:0]     o_dq_out,
  output logic                         o_dq_oe,
  output logic                         o_done,
  output logic [fws_pkg::FD_W-1:0]     o_rdata
);
  typedef enum {E_IDLE, E_SET, E_STB, E_HOLD} fws_cyc_t;
  fws_cyc_t   st_q;
  logic [3:0] cnt_q;
  logic       wr_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: setup, strobe, release; strobe ends before done so the
  // next read never starts before the write strobe has risen
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q    <= E_IDLE;
      cnt_q   <= 4'h0;
      wr_q    <= 1'b0;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
      o_addr  <= '0;
      o_dq_out<= '0;
      o_dq_oe <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= '0;
    end
    else
    begin
      o_done <= 1'b0;
      unique case (st_q)
        E_IDLE:
        begin
          if (i_start)
          begin
            st_q     <= E_SET;
            wr_q     <= i_req.write;
            o_addr   <= i_req.addr;
            o_dq_out <= i_req.data;
            o_dq_oe  <= i_req.write;
            o_ce_n   <= 1'b0;
          end
        end
        E_SET:
        begin
          st_q   <= E_STB;
          o_oe_n <= wr_q;
          o_we_n <= !wr_q;
          cnt_q  <= wr_q ? 4'(fws_pkg::WP_CYC) : 4'(fws_pkg::ACC_CYC);
        end
        E_STB:
        begin
          if (cnt_q == 4'h1)
          begin
            st_q   <= E_HOLD;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;   // rising write edge
            if (!wr_q)
              o_rdata <= i_dq_in;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        E_HOLD:
        begin
          st_q    <= E_IDLE;
          o_ce_n  <= 1'b1;
          o_dq_oe <= 1'b0;
          o_done  <= 1'b1;
        end
      endcase
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  no_overlap_a: assert property (!(!o_oe_n && !o_we_n))
    else $error("read and write strobes overlap");
endmodule // fws_bus_cycle
`default_nettype wire

/* hdl/fws_poll_ctrl.sv */
// host controller that polls flash program/erase status over the pins
//
// Contract
// - host combines bit 6 and bit 2 to find sector and mode
// - host starts toggle check with two consecutive full-bus reads
// - toggle stopped means done; next read gives array data
// - toggling with timeout flag high: host re-checks the toggle bit
// - still toggling on re-check: failed, host writes reset command
// - host that leaves polling restarts the algorithm from the top
// - after timeout failure host writes reset to return to read
// - host may skip bit 3 checks if commands come under 50 us apart
// - host checks bit 3 before and after each added sector erase
// - status reads go to the busy bank; others give array data
// - host reads status at the programmed or selected sector address
`timescale 1ns/1ps
`default_nettype none
module fws_poll_ctrl
#(
  parameter logic [fws_pkg::FD_W-1:0] RESET_CMD = 16'h00f0  // reset command
)
(
  input  wire logic                     i_clock,
  input  wire logic                     i_resetn,
  input  wire logic [7:0]               i_reg_addr,
  input  wire logic [31:0]              i_reg_wdata,
  input  wire logic                     i_reg_write,
  input  wire logic                     i_reg_read,
  output logic      [31:0]              o_reg_rdata,
  output logic                          o_flash_ce_n,
  output logic                          o_flash_oe_n,
  output logic                          o_flash_we_n,
  output logic      [fws_pkg::FA_W-1:0] o_flash_addr,
  output logic      [fws_pkg::FD_W-1:0] o_flash_dq_out,
  output logic                          o_flash_dq_oe,
  input  wire logic [fws_pkg::FD_W-1:0] i_flash_dq_in,
  input  wire logic                     i_ready_busy_open_drain_n
);
  typedef enum {S_IDLE, S_RD1, S_RD2, S_CHK, S_RD3, S_RD4, S_CHK2, S_RST,
                S_ARR, S_PRE, S_EWR, S_POST, S_WR} fws_state_t;

  fws_state_t                  state_q;
  fws_pkg::fws_req_t           req;
  logic                        start;
  logic                        sent_q;
  logic                        done;
  logic [fws_pkg::FD_W-1:0]    rdata;
  logic [fws_pkg::FA_W-1:0]    addr_q;
  logic [fws_pkg::FD_W-1:0]    data_q;
  logic [fws_pkg::FD_W-1:0]    v1_q;
  logic [fws_pkg::FD_W-1:0]    v2_q;
  logic [fws_pkg::FD_W-1:0]    result_q;
  logic                        skip_q;
  logic                        yield_q;
  logic                        ok_q;
  logic                        fail_q;
  logic                        paused_q;
  logic                        sect_q;
  logic                        eras_q;
  logic                        rej_q;
  logic                        lim_q;
  logic                        rdy_q;
  logic [1:0]                  nrd_q;
  logic                        ctrl_wr;
  logic [2:0]                  op;
  logic                        tog6;
  logic                        tog2;
  logic                        access;

  // a bit that changed between two reads
  function automatic logic toggled(input logic [fws_pkg::FD_W-1:0] a,
                                   input logic [fws_pkg::FD_W-1:0] b,
                                   input int pos);
    return a[pos] ^ b[pos];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode and status comparisons
  assign ctrl_wr = i_reg_write && (i_reg_addr == fws_pkg::REG_CTRL);
  assign op      = i_reg_wdata[fws_pkg::CTRL_OP_LSB +: 3];
  assign tog6    = toggled(v1_q, v2_q, fws_pkg::DQ_TOGGLE);
  assign tog2    = toggled(v1_q, v2_q, fws_pkg::DQ_SECT);
  assign access  = (state_q == S_RD1) || (state_q == S_RD2) ||
                   (state_q == S_RD3) || (state_q == S_RD4) ||
                   (state_q == S_RST) || (state_q == S_ARR) ||
                   (state_q == S_PRE) || (state_q == S_EWR) ||
                   (state_q == S_POST) || (state_q == S_WR);

  // every read goes to the software address, whichever bank it lies in
  always_comb
  begin
    req.write = (state_q == S_RST) || (state_q == S_EWR) ||
                (state_q == S_WR);
    req.addr  = addr_q;
    req.data  = (state_q == S_RST) ? RESET_CMD : data_q;
  end
  assign start = access && !sent_q;

  ////////////////////////////////////////////////////////////////////////////
  // one request per access state; cleared when the cycle completes
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      sent_q <= 1'b0;
    else if (done)
      sent_q <= 1'b0;
    else if (start)
      sent_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status algorithm sequencer
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      state_q <= S_IDLE;
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          if (ctrl_wr && op == fws_pkg::OP_POLL)
            state_q <= S_RD1;
          else if (ctrl_wr && op == fws_pkg::OP_WRITE)
            state_q <= S_WR;
          else if (ctrl_wr && op == fws_pkg::OP_RESET)
            state_q <= S_RST;
          else if (ctrl_wr && op == fws_pkg::OP_ADD)
            state_q <= i_reg_wdata[fws_pkg::CTRL_SKIP] ? S_EWR : S_PRE;
        end
        S_RD1:  if (done) state_q <= S_RD2;
        S_RD2:  if (done) state_q <= S_CHK;
        S_CHK:
        begin
          if (!tog6)
            state_q <= S_ARR;
          else if (v2_q[fws_pkg::DQ_LIMIT])
            state_q <= S_RD3;
          else if (yield_q)
            state_q <= S_IDLE;
          else
            state_q <= S_RD2;
        end
        S_RD3:  if (done) state_q <= S_RD4;
        S_RD4:  if (done) state_q <= S_CHK2;
        S_CHK2: state_q <= tog6 ? S_RST : S_ARR;
        S_RST:  if (done) state_q <= S_IDLE;
        S_ARR:  if (done) state_q <= S_IDLE;
        S_PRE:
        begin
          if (done)
            state_q <= rdata[fws_pkg::DQ_TIMER] ? S_IDLE : S_EWR;
        end
        S_EWR:  if (done) state_q <= skip_q ? S_IDLE : S_POST;
        S_POST: if (done) state_q <= S_IDLE;
        S_WR:   if (done) state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two compared reads; the first read of a pass restarts the pair
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      v1_q  <= fws_pkg::DATA_RST;
      v2_q  <= fws_pkg::DATA_RST;
      nrd_q <= 2'h0;
    end
    else if (done && (state_q == S_RD1 || state_q == S_RD3))
    begin
      v1_q  <= rdata;
      nrd_q <= 2'h1;
    end
    else if (done && (state_q == S_RD2 || state_q == S_RD4))
    begin
      v1_q  <= (nrd_q == 2'h2) ? v2_q : v1_q;  // keep polling pairwise
      v2_q  <= rdata;
      nrd_q <= 2'h2;
    end
    else if (state_q == S_IDLE)
      nrd_q <= 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outcome flags; a new order clears all of them but sector and mode
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ok_q     <= 1'b0;
      fail_q   <= 1'b0;
      paused_q <= 1'b0;
      rej_q    <= 1'b0;
      lim_q    <= 1'b0;
      sect_q   <= 1'b0;
      eras_q   <= 1'b0;
      result_q <= fws_pkg::DATA_RST;
    end
    else if (state_q == S_IDLE && ctrl_wr && op != 3'h0)
    begin
      ok_q     <= 1'b0;
      fail_q   <= 1'b0;
      paused_q <= 1'b0;
      rej_q    <= 1'b0;
      lim_q    <= 1'b0;
    end
    else
    begin
      if (state_q == S_CHK)
      begin
        sect_q   <= tog2;
        eras_q   <= tog6;
        lim_q    <= v2_q[fws_pkg::DQ_LIMIT];
        paused_q <= tog6 && !v2_q[fws_pkg::DQ_LIMIT] && yield_q;
      end
      if (state_q == S_CHK2 && tog6)
        fail_q <= 1'b1;
      if (state_q == S_ARR && done)
        ok_q <= 1'b1;
      // bit 3 high before or after the add means it may be refused
      if ((state_q == S_PRE || state_q == S_POST) && done &&
          rdata[fws_pkg::DQ_TIMER])
        rej_q <= 1'b1;
      if (done && !req.write)
        result_q <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      addr_q  <= fws_pkg::ADDR_RST;
      data_q  <= fws_pkg::DATA_RST;
      skip_q  <= 1'b0;
      yield_q <= 1'b0;
      rdy_q   <= 1'b1;
    end
    else
    begin
      rdy_q <= i_ready_busy_open_drain_n;
      // address and data only change while idle, so a cycle never tears
      if (i_reg_write && state_q == S_IDLE && i_reg_addr == fws_pkg::REG_ADDR)
        addr_q <= i_reg_wdata[fws_pkg::FA_W-1:0];
      if (i_reg_write && state_q == S_IDLE && i_reg_addr == fws_pkg::REG_DATA)
        data_q <= i_reg_wdata[fws_pkg::FD_W-1:0];
      if (ctrl_wr)
        yield_q <= i_reg_wdata[fws_pkg::CTRL_YIELD];
      if (ctrl_wr && state_q == S_IDLE)
        skip_q <= i_reg_wdata[fws_pkg::CTRL_SKIP];
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= 32'h0000_0000;
    else if (i_reg_read)
    begin
      unique case (i_reg_addr)
        fws_pkg::REG_CTRL:
          o_reg_rdata <= 32'({yield_q, skip_q, 3'h0});
        fws_pkg::REG_ADDR:   o_reg_rdata <= 32'(addr_q);
        fws_pkg::REG_DATA:   o_reg_rdata <= 32'(data_q);
        fws_pkg::REG_STATUS:
          o_reg_rdata <= 32'({lim_q, rdy_q, rej_q, eras_q, sect_q,
                              paused_q, fail_q, ok_q, state_q != S_IDLE});
        fws_pkg::REG_RESULT: o_reg_rdata <= 32'(result_q);
        default:             o_reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      o_reg_rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin-level cycle engine
  fws_bus_cycle u_cycle
  (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_start  (start),
    .i_req    (req),
    .i_dq_in  (i_flash_dq_in),
    .o_ce_n   (o_flash_ce_n),
    .o_oe_n   (o_flash_oe_n),
    .o_we_n   (o_flash_we_n),
    .o_addr   (o_flash_addr),
    .o_dq_out (o_flash_dq_out),
    .o_dq_oe  (o_flash_dq_oe),
    .o_done   (done),
    .o_rdata  (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sequence pair_read_s;
    state_q == S_RD2 && done;
  endsequence

  // the re-check is two fresh reads ending in a second decision
  sequence recheck_s;
    state_q == S_RD3 ##[1:40] state_q == S_CHK2;
  endsequence

  two_reads_a: assert property (state_q == S_CHK |-> nrd_q == 2'h2)
    else $error("toggle decided without two reads");
  pair_chk_a: assert property (pair_read_s |=> state_q == S_CHK)
    else $error("second read not followed by decision");
  array_next_a: assert property ((state_q == S_CHK && !tog6) |=>
                                 state_q == S_ARR)
    else $error("no array read after toggling stopped");
  recheck_a: assert property ((state_q == S_CHK && tog6 &&
                               v2_q[fws_pkg::DQ_LIMIT]) |=> recheck_s)
    else $error("toggle not re-checked with timeout high");
  fail_reset_a: assert property ((state_q == S_CHK2 && tog6) |=>
                                 fail_q && state_q == S_RST)
    else $error("failed check did not reset");
  reset_cmd_a: assert property ((start && state_q == S_RST) |->
                                req.write && req.data == RESET_CMD)
    else $error("reset command not written");
  restart_a: assert property ((state_q == S_IDLE && ctrl_wr &&
                               op == fws_pkg::OP_POLL) |=>
                              state_q == S_RD1 && nrd_q == 2'h0)
    else $error("poll did not restart from first read");
  paused_idle_a: assert property ($rose(paused_q) |-> state_q == S_IDLE)
    else $error("pause without leaving the algorithm");
  // watch the pins, not the request, so a torn address would show
  read_addr_a: assert property (!o_flash_oe_n |->
                                o_flash_addr == addr_q)
    else $error("status read at wrong address");
  dq3_before_a: assert property ((start && state_q == S_EWR &&
                                  !skip_q) |-> $past(state_q) == S_PRE)
    else $error("sector add without prior timer check");
  mode_pair_a: assert property (state_q == S_CHK |=>
                                sect_q == $past(tog2) &&
                                eras_q == $past(tog6))
    else $error("sector and mode not taken together");
endmodule // fws_poll_ctrl
`default_nettype wire

/* sim/fws_flash_model.sv */
// behavioural flash that answers status polls on its pins
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model
(
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [20:0] i_addr,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic             o_ready_busy_open_drain_n
);
  logic [15:0] arr = 16'h5a3c, pgm = 16'h0000, last = 16'h0000, st, word;
  logic busy = 0, ers = 0, sus = 0, fail = 0, bad = 0, dq3 = 0;
  logic t6 = 0, t2 = 0, bank = 0;
  logic [3:0] sect = 4'h0;
  int n_reads = 1, left = 0, adds = 0;
  //////////////////////////////////////////////////////////////////////
  // status word of the busy bank
  always_comb
  begin
    st = 16'h0000;
    st[7] = ers ? sus : ~pgm[7];
    st[6] = t6;
    st[5] = fail;
    st[3] = ers & dq3;
    st[2] = t2;
  end
  assign word = (busy && i_addr[20] == bank) ? st : arr;
  // no pull-up on dq, so a released bus shows the inverse of the last word
  assign o_dq = (!i_ce_n && !i_oe_n) ? word : ~last;
  assign o_ready_busy_open_drain_n = !(busy && !sus);
  //////////////////////////////////////////////////////////////////////
  // a read ends at the rising output enable
  always @(posedge i_oe_n)
  begin
    if (!i_ce_n)
    begin
      last = word;
      if (busy && i_addr[20] == bank)
      begin
        if (ers && i_addr[15:12] == sect) t2 = ~t2;
        if (!sus) t6 = ~t6;
        if (!sus) left = left - 1;
        if (!sus && left == 0 && bad) fail = 1'b1;
        if (!sus && left == 0 && !bad)
        begin
          busy = 1'b0;
          arr = ers ? 16'hffff : (arr & pgm);
        end
      end
    end
  end
  // a write ends at the rising write strobe; status counts from here
  always @(posedge i_we_n)
  begin
    if (!i_ce_n)
    begin
      if (i_dq == 16'h00f0)
        {busy, fail, sus, ers} = 4'h0;
      else if (!busy)
      begin
        {busy, ers, sus, pgm, bank} = {3'b100, i_dq, i_addr[20]};
        left = n_reads;
        bad = |(i_dq & ~arr);
      end
      else if (ers && !dq3) adds = adds + 1;
      // anything else is dropped while erasing
    end
  end
  // erase start, command decoding is left out of this model;
  // tm low stands for a sector erase whose add window is still open; its timer bit never rises
  task automatic start_erase(input logic [20:0] a, input logic tm, s);
    {busy, ers, sus, dq3, bad, fail} = {2'b11, s, tm, 2'b00};
    {bank, sect} = {a[20], a[15:12]};
    left = n_reads;
    adds = 0;
  endtask
endmodule // fws_flash_model
`default_nettype wire

/* sim/fws_poll_ctrl_tb.sv */
// self-checking bench for the flash status poll controller
`timescale 1ns/1ps
`default_nettype none
module fws_poll_ctrl_tb;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, ce_n, oe_n, we_n, oe, rb_n;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0, rdat, s;
  logic [20:0] fa;
  logic [15:0] dqo, dqf, dq;
  int n_mismatch = 0, n_compared = 0;
  always #50 clk = ~clk;
  // wire level: controller wins while its enable is high
  assign dq = oe ? dqo : dqf;
  fws_poll_ctrl dut (.i_clock(clk), .i_resetn(rstn), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdat),
    .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
    .o_flash_addr(fa), .o_flash_dq_out(dqo), .o_flash_dq_oe(oe),
    .i_flash_dq_in(dq), .i_ready_busy_open_drain_n(rb_n));
  fws_flash_model flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_addr(fa), .i_dq(dq), .o_dq(dqf), .o_ready_busy_open_drain_n(rb_n));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bchk(input string what, input logic exp, input int idx);
    check(what, {31'h0, exp}, {31'h0, s[idx]});
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {ra, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    {ra, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    s = rdat;
  endtask
  // start an operation and poll status under a bounded count
  task automatic run(input logic [31:0] ctrl);
    wr_reg(fws_pkg::REG_CTRL, ctrl);
    s = 32'h1;
    for (int i = 0; i < 400 && s[fws_pkg::ST_BUSY] !== 1'b0; i++)
      rd_reg(fws_pkg::REG_STATUS);
    bchk("busy", 1'b0, fws_pkg::ST_BUSY);
  endtask
  task automatic prog(input logic [20:0] a, input logic [15:0] d, input int n);
    flash.n_reads = n;
    wr_reg(fws_pkg::REG_ADDR, {11'h0, a});
    wr_reg(fws_pkg::REG_DATA, {16'h0, d});
    run({29'h0, fws_pkg::OP_WRITE});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(fws_pkg::REG_STATUS);
    bchk("ready", 1'b1, fws_pkg::ST_RDY);
    rd_reg(8'h20);
    check("unmapped", 32'h0, s);
  endtask
  task automatic t_prog_ok;
    prog(21'h000100, 16'h1804, 3);
    rd_reg(fws_pkg::REG_STATUS);
    bchk("ready", 1'b0, fws_pkg::ST_RDY);
    run({29'h0, fws_pkg::OP_POLL});
    bchk("ok", 1'b1, fws_pkg::ST_OK);
    bchk("ready", 1'b1, fws_pkg::ST_RDY);
    rd_reg(fws_pkg::REG_RESULT);
    check("array", 32'h1804, s);
  endtask
  // writing ones over zeros never finishes and trips the limit flag
  task automatic t_prog_fail;
    prog(21'h000100, 16'hffff, 2);
    run({29'h0, fws_pkg::OP_POLL});
    bchk("fail", 1'b1, fws_pkg::ST_FAIL);
    bchk("limit", 1'b1, fws_pkg::ST_LIM);
    check("flash busy", 32'h0, {31'h0, flash.busy});
  endtask
  task automatic t_yield;
    prog(21'h000100, 16'h0004, 40);
    run(32'h00000011); // poll with yield
    bchk("paused", 1'b1, fws_pkg::ST_PAUS);
    wr_reg(fws_pkg::REG_ADDR, 32'h00100100);
    run({29'h0, fws_pkg::OP_POLL});
    rd_reg(fws_pkg::REG_RESULT);
    check("other bank", 32'h1804, s);
    wr_reg(fws_pkg::REG_ADDR, 32'h00000100);
    run({29'h0, fws_pkg::OP_POLL});
    bchk("ok", 1'b1, fws_pkg::ST_OK);
    rd_reg(fws_pkg::REG_RESULT);
    check("array", 32'h0004, s);
  endtask
  task automatic t_erase;
    flash.n_reads = 12;
    flash.start_erase(21'h003000, 1'b0, 1'b0);
    wr_reg(fws_pkg::REG_ADDR, 32'h00003000);
    run({29'h0, fws_pkg::OP_ADD});
    bchk("rejected", 1'b0, fws_pkg::ST_REJ);
    check("adds", 32'h1, flash.adds);
    // mode bits only mean something while the erase still runs
    run(32'h00000011); // poll with yield
    bchk("sector", 1'b1, fws_pkg::ST_SECT);
    bchk("erasing", 1'b1, fws_pkg::ST_ERAS);
    run({29'h0, fws_pkg::OP_POLL});
    bchk("ok", 1'b1, fws_pkg::ST_OK);
    rd_reg(fws_pkg::REG_RESULT);
    check("erased", 32'hffff, s);
  endtask
  task automatic t_reject;
    flash.start_erase(21'h003000, 1'b1, 1'b0);
    run({29'h0, fws_pkg::OP_ADD});
    bchk("rejected", 1'b1, fws_pkg::ST_REJ);
    check("adds", 32'h0, flash.adds);
    flash.start_erase(21'h003000, 1'b0, 1'b1);
    rd_reg(fws_pkg::REG_STATUS);
    bchk("ready", 1'b1, fws_pkg::ST_RDY);
    run({29'h0, fws_pkg::OP_RESET});
    check("flash busy", 32'h0, {31'h0, flash.busy});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_prog_ok();
    t_prog_fail();
    t_yield();
    t_erase();
    t_reject();
    end_sim();
  end
  // watchdog at 30000 cycles, far beyond the few hundred cycles the tests need
  initial
  begin
    #3000000;
    n_mismatch++;
    end_sim();
  end
endmodule // fws_poll_ctrl_tb
`default_nettype wire
